// ===== rtl/cfpb_pkg.sv
// Purpose: Constants for the configuration fuse protection bank
// Assumes: Byte-wide fuse registers in the configuration space
// Notes: Programmed bits read 0, unprogrammed bits read 1
package cfpb_pkg;
  // ==========================================================
  // Register addresses (configuration space, table read only)
  localparam logic [21:0] CFG_SPACE_BASE = 22'h300000;
  localparam logic [21:0] CFG_SPACE_LAST = 22'h3000FF;
  localparam logic [21:0] ADDR_RESET_PIN_AND_ROUTING = 22'h300005;
  localparam logic [21:0] ADDR_DEBUG_AND_CORE_OPTION = 22'h300006;
  localparam logic [21:0] ADDR_BLOCK_CODE_PROTECT = 22'h300008;
  localparam logic [21:0] ADDR_BOOT_CODE_PROTECT = 22'h300009;
  localparam logic [21:0] ADDR_BLOCK_WRITE_PROTECT = 22'h30000A;
  localparam logic [21:0] ADDR_BOOT_CONFIG_WRITE_PROTECT = 22'h30000B;
  // ==========================================================
  // Implemented bit masks; other bits read as zero
  localparam logic [7:0] MASK_RESET_PIN_AND_ROUTING = 8'h87;
  localparam logic [7:0] MASK_DEBUG_AND_CORE_OPTION = 8'hC5;
  localparam logic [7:0] MASK_BLOCK_PROTECT = 8'h0F;
  localparam logic [7:0] MASK_BOOT_CODE_PROTECT = 8'h40;
  localparam logic [7:0] MASK_BOOT_CONFIG_WRITE_PROTECT = 8'h60;
  // ==========================================================
  // Unprogrammed values
  localparam logic [7:0] UNPROG_RESET_PIN_AND_ROUTING = 8'h83;
  localparam logic [7:0] UNPROG_DEBUG_AND_CORE_OPTION = 8'h85;
  localparam logic [7:0] UNPROG_BLOCK_PROTECT = 8'h0F;
  localparam logic [7:0] UNPROG_BOOT_CODE_PROTECT = 8'h40;
  localparam logic [7:0] UNPROG_BOOT_CONFIG_WRITE_PROTECT = 8'h60;
  // ==========================================================
  // Field positions
  localparam int BIT_RESET_PIN_ENABLE = 7;
  localparam int BIT_LOW_POWER_TIMER_OSC = 2;
  localparam int BIT_PORT_ANALOG_DEFAULT = 1;
  localparam int BIT_CAPCOMP2_ROUTING = 0;
  localparam int BIT_DEBUG_DISABLE = 7;
  localparam int BIT_EXTENDED_INSTR_ENABLE = 6;
  localparam int BIT_SINGLE_SUPPLY_PROG_ENABLE = 2;
  localparam int BIT_STACK_OVERFLOW_RESET_ENABLE = 0;
  localparam int BIT_CODE_PROTECT_BOOT = 6;
  localparam int BIT_WRITE_PROTECT_BOOT = 6;
  localparam int BIT_WRITE_PROTECT_CONFIG = 5;
  // ==========================================================
  // Block maps (upper bound of each block, 22-bit program address)
  localparam logic [21:0] BOOT_LAST = 22'h0007FF;
  localparam logic [21:0] SMALL_BLOCK0_LAST = 22'h001FFF;
  localparam logic [21:0] SMALL_BLOCK1_LAST = 22'h003FFF;
  localparam logic [21:0] SMALL_BLOCK2_LAST = 22'h005FFF;
  localparam logic [21:0] SMALL_BLOCK3_LAST = 22'h007FFF;
  localparam logic [21:0] LARGE_BLOCK0_LAST = 22'h003FFF;
  localparam logic [21:0] LARGE_BLOCK1_LAST = 22'h007FFF;
  localparam logic [21:0] LARGE_BLOCK2_LAST = 22'h00BFFF;
  localparam logic [21:0] LARGE_BLOCK3_LAST = 22'h00FFFF;
  // Analog configuration register low nibble values at reset
  localparam logic [3:0] ANALOG_CFG_ALL_ANALOG = 4'h0;
  localparam logic [3:0] ANALOG_CFG_PORT_B_DIGITAL = 4'h7;
endpackage

// ===== rtl/cfpb_block_decode.sv
// Purpose: Map a program address to a protection block index
// Assumes: Address within user program memory space
// Notes: Index 4 means boot block, 5 means outside all blocks
`timescale 1ns/1ps
module cfpb_block_decode (
  input wire logic [21:0] addr_i,
  input wire logic large_mem_i,
  output logic [2:0] block_o
);
  // ==========================================================
  // Combinational block lookup
  always_comb begin
    if (addr_i <= cfpb_pkg::BOOT_LAST) begin
      block_o = 3'h4; // R14
    end else if (large_mem_i) begin
      // Map for 48K and 64K parts
      if (addr_i <= cfpb_pkg::LARGE_BLOCK0_LAST) block_o = 3'h0; // R11
      else if (addr_i <= cfpb_pkg::LARGE_BLOCK1_LAST) block_o = 3'h1;
      else if (addr_i <= cfpb_pkg::LARGE_BLOCK2_LAST) block_o = 3'h2;
      else if (addr_i <= cfpb_pkg::LARGE_BLOCK3_LAST) block_o = 3'h3;
      else block_o = 3'h5;
    end else begin
      // Map for 16K and 32K parts
      if (addr_i <= cfpb_pkg::SMALL_BLOCK0_LAST) block_o = 3'h0; // R10
      else if (addr_i <= cfpb_pkg::SMALL_BLOCK1_LAST) block_o = 3'h1;
      else if (addr_i <= cfpb_pkg::SMALL_BLOCK2_LAST) block_o = 3'h2;
      else if (addr_i <= cfpb_pkg::SMALL_BLOCK3_LAST) block_o = 3'h3;
      else block_o = 3'h5;
    end
  end
endmodule // cfpb_block_decode

// ===== rtl/cfpb_fuse_bank.sv
// Purpose: Configuration fuse bank with protection checks and decoded controls
// Assumes: Fuse array image presented on fuse_*_i; table read port synchronous
// Notes: Fuses captured after reset release and held; programming mode may clear
// Notes: Blocks above NUM_BLOCKS read as unprotected and cannot be cleared
//
// Behaviour
// R1 - Reset pin enable selects external reset or input
// R2 - Timer oscillator low-power selection
// R3 - Port analog default sets analog reset state
// R4 - Channel 2 routing on port C or B
// R5 - Debugger active when fuse is zero
// R6 - Extended instruction set enable
// R7 - Single-supply programming enable
// R8 - Stack full or underflow triggers reset
// R9 - Unimplemented bits read zero
// R10 - Small part block address map
// R11 - Large part block address map
// R12 - Block code protect when zero
// R13 - Block write protect when zero
// R14 - Boot block code protect when zero
// R15 - Boot block write protect when zero
// R16 - Config space write protect when zero; code raises table_wr_denied_o but still applies the write in programming mode
// R17 - Config protect writable only in programming mode
// R18 - Absent upper block bits kept at one
// R19 - Protection bits only clear toward zero
// R20 - Programmed reads zero, unprogrammed reads one
// R21 - Config space reached only by table reads
// R22 - Fuses sampled at reset and held
`timescale 1ns/1ps
module cfpb_fuse_bank #(
  parameter int NUM_BLOCKS = 4 // Implemented protection blocks
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Fuse array image
  input wire logic [7:0] fuse_reset_pin_and_routing_i,
  input wire logic [7:0] fuse_debug_and_core_option_i,
  input wire logic [7:0] fuse_block_code_protect_i,
  input wire logic [7:0] fuse_boot_code_protect_i,
  input wire logic [7:0] fuse_block_write_protect_i,
  input wire logic [7:0] fuse_boot_and_config_write_protect_i,
  input wire logic large_mem_i,
  input wire logic prog_mode_i,
  // Table read and write port
  input wire logic table_rd_i,
  input wire logic table_wr_i,
  input wire logic [21:0] table_addr_i,
  input wire logic [7:0] table_wdata_i,
  output logic [7:0] table_rdata_o,
  output logic table_rd_denied_o,
  output logic table_wr_denied_o,
  // Stack events
  input wire logic stack_full_i,
  input wire logic stack_underflow_i,
  // Program memory access checks
  input wire logic [21:0] pm_addr_i,
  input wire logic pm_ext_read_i,
  input wire logic pm_wr_i,
  output logic pm_read_blocked_o,
  output logic pm_wr_blocked_o,
  // Decoded controls
  output logic reset_pin_enable_o,
  output logic port_e_pin_3_input_en_o,
  output logic low_power_timer_osc_o,
  output logic [3:0] analog_config_reset_o,
  output logic capcomp2_on_port_c_pin_1_o,
  output logic debugger_active_o,
  output logic extended_instr_enable_o,
  output logic single_supply_prog_enable_o,
  output logic stack_reset_o
);
  // ==========================================================
  // Held fuse registers
  logic [7:0] routing_reg; // Reset pin, timer, analog and routing byte
  logic [7:0] core_opt_reg; // Debugger and core option byte
  logic [7:0] cp_reg; // Per-block code protection, 0 means protected
  logic [7:0] boot_cp_reg; // Boot block code protection
  logic [7:0] wp_reg; // Per-block write protection, 0 means protected
  logic [7:0] wpb_reg; // Boot block and config space write protection
  logic loaded_reg; // High once fuses were captured
  // ==========================================================
  // Next values and helper nets
  logic [7:0] cp_next; // Code protection after a clearing write
  logic [7:0] wp_next; // Write protection after a clearing write
  logic [2:0] pm_block; // Block of program access
  logic in_cfg; // Table address inside config space
  logic [7:0] rdata_next; // Byte selected by the table address
  logic [7:0] blk_mask; // Implemented block bits

  // Bits above the implemented blocks stay at one, so a smaller part
  // never reports an absent block as protected
  assign blk_mask = 8'((1 << NUM_BLOCKS) - 1); // R18
  // Window of the configuration space seen by table accesses
  assign in_cfg = (table_addr_i >= cfpb_pkg::CFG_SPACE_BASE) &&
                  (table_addr_i <= cfpb_pkg::CFG_SPACE_LAST);

  // ==========================================================
  // Block lookup for program accesses
  cfpb_block_decode u_decode (
    .addr_i(pm_addr_i),
    .large_mem_i(large_mem_i),
    .block_o(pm_block)
  );

  // ==========================================================
  // Clear-only update of protection bytes
  // A write only moves bits from one to zero; a one in the data leaves
  // the bit as it is, so protection can never be lifted again
  always_comb begin
    // Hold by default
    cp_next = cp_reg;
    wp_next = wp_reg;
    // Clearing happens only in programming mode
    if (table_wr_i && prog_mode_i) begin
      // Block code protection byte
      if (table_addr_i == cfpb_pkg::ADDR_BLOCK_CODE_PROTECT) begin
        cp_next = cp_reg & (table_wdata_i | ~blk_mask); // R19 R18
      end
      // Block write protection byte
      if (table_addr_i == cfpb_pkg::ADDR_BLOCK_WRITE_PROTECT) begin
        wp_next = wp_reg & (table_wdata_i | ~blk_mask); // R19
      end
    end
  end

  // ==========================================================
  // Capture fuses after reset release, then hold
  // The image is taken once, on the first edge after reset; later
  // changes on the fuse inputs are ignored until the next reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Unprogrammed values while reset is held
      loaded_reg <= 1'b0;
      routing_reg <= cfpb_pkg::UNPROG_RESET_PIN_AND_ROUTING;
      core_opt_reg <= cfpb_pkg::UNPROG_DEBUG_AND_CORE_OPTION;
      cp_reg <= cfpb_pkg::UNPROG_BLOCK_PROTECT;
      boot_cp_reg <= cfpb_pkg::UNPROG_BOOT_CODE_PROTECT;
      wp_reg <= cfpb_pkg::UNPROG_BLOCK_PROTECT;
      wpb_reg <= cfpb_pkg::UNPROG_BOOT_CONFIG_WRITE_PROTECT;
    end else if (!loaded_reg) begin
      // One-time sample of the fuse image
      loaded_reg <= 1'b1; // R22
      routing_reg <= fuse_reset_pin_and_routing_i & cfpb_pkg::MASK_RESET_PIN_AND_ROUTING; // R9
      core_opt_reg <= fuse_debug_and_core_option_i & cfpb_pkg::MASK_DEBUG_AND_CORE_OPTION;
      // Absent blocks are read as unprotected
      cp_reg <= (fuse_block_code_protect_i | ~blk_mask) & cfpb_pkg::MASK_BLOCK_PROTECT;
      boot_cp_reg <= fuse_boot_code_protect_i & cfpb_pkg::MASK_BOOT_CODE_PROTECT;
      wp_reg <= (fuse_block_write_protect_i | ~blk_mask) & cfpb_pkg::MASK_BLOCK_PROTECT;
      wpb_reg <= fuse_boot_and_config_write_protect_i &
                 cfpb_pkg::MASK_BOOT_CONFIG_WRITE_PROTECT;
    end else begin
      // Block bytes follow the clear-only next values
      cp_reg <= cp_next;
      wp_reg <= wp_next;
      // Boot bits clear-only; config protect only in programming mode
      if (table_wr_i && prog_mode_i) begin // R17
        // Boot block code protection
        if (table_addr_i == cfpb_pkg::ADDR_BOOT_CODE_PROTECT) begin
          boot_cp_reg <= boot_cp_reg & table_wdata_i; // R19
        end
        // Boot block and config space write protection
        if (table_addr_i == cfpb_pkg::ADDR_BOOT_CONFIG_WRITE_PROTECT) begin
          wpb_reg <= wpb_reg & table_wdata_i; // R19 R17
        end
      end
    end
  end

  // ==========================================================
  // Table read mux; unmapped reads zero
  always_comb begin
    case (table_addr_i)
      // Held bytes, already masked so unimplemented bits read zero
      cfpb_pkg::ADDR_RESET_PIN_AND_ROUTING: rdata_next = routing_reg; // R20
      cfpb_pkg::ADDR_DEBUG_AND_CORE_OPTION: rdata_next = core_opt_reg;
      cfpb_pkg::ADDR_BLOCK_CODE_PROTECT: rdata_next = cp_reg;
      cfpb_pkg::ADDR_BOOT_CODE_PROTECT: rdata_next = boot_cp_reg;
      cfpb_pkg::ADDR_BLOCK_WRITE_PROTECT: rdata_next = wp_reg;
      cfpb_pkg::ADDR_BOOT_CONFIG_WRITE_PROTECT: rdata_next = wpb_reg;
      // Reserved and unmapped addresses
      default: rdata_next = 8'h00; // R9
    endcase
  end

  // ==========================================================
  // Table read data, one cycle after request
  // The byte is kept until the next read, so a slow reader may take it
  // later
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      table_rdata_o <= 8'h00;
    end else if (table_rd_i) begin
      // Outside the configuration space nothing is returned
      table_rdata_o <= in_cfg ? rdata_next : 8'h00; // R21
    end
  end

  // ==========================================================
  // Table refusal flags, one cycle per request cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      table_rd_denied_o <= 1'b0;
      table_wr_denied_o <= 1'b0;
    end else begin
      // Reads reach only the configuration space
      table_rd_denied_o <= table_rd_i && !in_cfg; // R21
      // Config space writes flagged when protected or outside programming; a protected write in programming mode still clears bits
      table_wr_denied_o <= table_wr_i && in_cfg &&
        (!prog_mode_i || !wpb_reg[cfpb_pkg::BIT_WRITE_PROTECT_CONFIG]); // R16 R17
    end
  end

  // ==========================================================
  // Program memory read protection check
  // The flag stands for one cycle per request cycle; the map follows
  // the memory size input, so both part sizes share one check
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pm_read_blocked_o <= 1'b0;
    end else if (pm_block == 3'h4) begin
      // Boot block
      pm_read_blocked_o <= pm_ext_read_i && !boot_cp_reg[cfpb_pkg::BIT_CODE_PROTECT_BOOT]; // R14
    end else if (pm_block < 3'h4) begin
      // One of the numbered blocks
      pm_read_blocked_o <= pm_ext_read_i && !cp_reg[pm_block[1:0]]; // R12
    end else begin
      // Beyond the last block nothing is protected
      pm_read_blocked_o <= 1'b0;
    end
  end

  // ==========================================================
  // Program memory write protection check
  // Same block map as the read check, with the write protection bytes
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pm_wr_blocked_o <= 1'b0;
    end else if (pm_block == 3'h4) begin
      // Boot block
      pm_wr_blocked_o <= pm_wr_i && !wpb_reg[cfpb_pkg::BIT_WRITE_PROTECT_BOOT]; // R15
    end else if (pm_block < 3'h4) begin
      // One of the numbered blocks
      pm_wr_blocked_o <= pm_wr_i && !wp_reg[pm_block[1:0]]; // R13
    end else begin
      // Beyond the last block nothing is protected
      pm_wr_blocked_o <= 1'b0;
    end
  end

  // ==========================================================
  // Reset pin function from held fuses
  // Both views of the shared pin come from one bit, so they can never
  // disagree
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_pin_enable_o <= 1'b1;
      port_e_pin_3_input_en_o <= 1'b0;
    end else begin
      reset_pin_enable_o <= routing_reg[cfpb_pkg::BIT_RESET_PIN_ENABLE]; // R1
      port_e_pin_3_input_en_o <= !routing_reg[cfpb_pkg::BIT_RESET_PIN_ENABLE]; // R1
    end
  end

  // ==========================================================
  // Timer oscillator, analog default and channel 2 routing
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_power_timer_osc_o <= 1'b0;
      analog_config_reset_o <= cfpb_pkg::ANALOG_CFG_ALL_ANALOG;
      capcomp2_on_port_c_pin_1_o <= 1'b1;
    end else begin
      low_power_timer_osc_o <= routing_reg[cfpb_pkg::BIT_LOW_POWER_TIMER_OSC]; // R2
      // Low port B pins come out of reset analog or digital
      analog_config_reset_o <= routing_reg[cfpb_pkg::BIT_PORT_ANALOG_DEFAULT] ?
        cfpb_pkg::ANALOG_CFG_ALL_ANALOG : cfpb_pkg::ANALOG_CFG_PORT_B_DIGITAL; // R3
      capcomp2_on_port_c_pin_1_o <= routing_reg[cfpb_pkg::BIT_CAPCOMP2_ROUTING]; // R4
    end
  end

  // ==========================================================
  // Debugger and core options
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      debugger_active_o <= 1'b0;
      extended_instr_enable_o <= 1'b0;
      single_supply_prog_enable_o <= 1'b1;
    end else begin
      // Debugger runs when its fuse is programmed
      debugger_active_o <= !core_opt_reg[cfpb_pkg::BIT_DEBUG_DISABLE]; // R5
      extended_instr_enable_o <= core_opt_reg[cfpb_pkg::BIT_EXTENDED_INSTR_ENABLE]; // R6
      single_supply_prog_enable_o <= core_opt_reg[cfpb_pkg::BIT_SINGLE_SUPPLY_PROG_ENABLE]; // R7
    end
  end

  // ==========================================================
  // Stack fault reset request
  // Registered, so the request follows the stack event by one cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stack_reset_o <= 1'b0;
    end else begin
      // Full and underflow both count when the fuse allows it
      stack_reset_o <= core_opt_reg[cfpb_pkg::BIT_STACK_OVERFLOW_RESET_ENABLE] &&
                       (stack_full_i || stack_underflow_i); // R8
    end
  end
endmodule // cfpb_fuse_bank

// ===== sim/cfpb_fuse_bank_monitor.sv
// Purpose: Concurrent checks on the fuse bank ports
// Assumes: One clock domain, asynchronous active-high reset
// Notes: Attached by bind from the bench top file
`timescale 1ns/1ps
module cfpb_fuse_bank_monitor (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic prog_mode_i,
  input wire logic table_rd_i,
  input wire logic table_wr_i,
  input wire logic [21:0] table_addr_i,
  input wire logic [7:0] table_rdata_o,
  input wire logic table_rd_denied_o,
  input wire logic table_wr_denied_o,
  input wire logic stack_full_i,
  input wire logic stack_underflow_i,
  input wire logic reset_pin_enable_o,
  input wire logic port_e_pin_3_input_en_o,
  input wire logic [3:0] analog_config_reset_o,
  input wire logic debugger_active_o,
  input wire logic stack_reset_o
);
  // ==========================================================
  // Config window decode
  logic in_cfg; // Address inside the configuration window
  assign in_cfg = table_addr_i >= cfpb_pkg::CFG_SPACE_BASE &&
    table_addr_i <= cfpb_pkg::CFG_SPACE_LAST;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Read, write and decode checks
  a_rd_outside_denied: assert property (table_rd_i && !in_cfg |=> table_rd_denied_o)
    else $error("read outside config space not refused");
  a_rd_outside_zero: assert property (table_rd_i && !in_cfg |=> table_rdata_o == 8'h00)
    else $error("read outside config space gave data");
  a_rd_inside_ok: assert property (table_rd_i && in_cfg |=> !table_rd_denied_o)
    else $error("read inside config space refused");
  a_deny_has_cause: assert property (table_rd_denied_o |-> $past(table_rd_i && !in_cfg))
    else $error("read refusal without a request");
  a_unimpl_zero: assert property (table_rd_i && table_addr_i == 22'h300006 |=>
    (table_rdata_o & 8'h3A) == 8'h00) else $error("unimplemented bits not zero");
  a_wr_outside_mode: assert property (table_wr_i && in_cfg && !prog_mode_i |=>
    table_wr_denied_o) else $error("config write outside programming mode accepted");
  a_pin_inverse: assert property (port_e_pin_3_input_en_o == !reset_pin_enable_o)
    else $error("pin input enable not inverse of reset pin enable");
  a_analog_code: assert property (analog_config_reset_o inside {4'h0, 4'h7})
    else $error("analog reset code out of range");
  a_stack_cause: assert property (stack_reset_o |-> $past(stack_full_i || stack_underflow_i))
    else $error("stack reset without stack event");
  a_ctrl_held: assert property ($past(rst_i, 3) ||
    $stable(debugger_active_o) && $stable(reset_pin_enable_o)) else $error("controls moved");
endmodule // cfpb_fuse_bank_monitor

// ===== sim/cfpb_fuse_bank_bench.sv
// Purpose: Self-checking bench for the configuration fuse bank
// Assumes: Registered answers read 1 ns after the taking edge
// Notes: Two fuse images, each loaded through its own reset
`timescale 1ns/1ps
module cfpb_fuse_bank_bench;
  // ==========================================================
  // Stimulus and observed signals
  logic clk = 1'b0, rst = 1'b1, lg = 1'b0, pg = 1'b0, rd = 1'b0, tw = 1'b0;
  logic sf = 1'b0, su = 1'b0, pr = 1'b0, pw = 1'b0;
  logic [21:0] ta = 22'h000000, pa = 22'h000000;
  logic [7:0] wd = 8'h00, rdat;
  logic [7:0] fz [6] = '{default: 8'hFF}; // Fuse image inputs
  logic [7:0] ex [6]; // Expected register contents
  logic [3:0] acr;
  logic rdn, wdn, prb, pwb, rpe, pe3, lpo, ccp, dba, xin, ssp, srs;
  int fail_count = 0, n_compared = 0;
  localparam logic [21:0] AD [6] = '{22'h300005, 22'h300006, 22'h300008, 22'h300009,
    22'h30000A, 22'h30000B};
  localparam logic [7:0] MK [6] = '{8'h87, 8'hC5, 8'h0F, 8'h40, 8'h0F, 8'h60};
  always #5 clk = ~clk;
  cfpb_fuse_bank #(.NUM_BLOCKS(4)) dut (.core_clk_i(clk), .rst_i(rst),
    .fuse_reset_pin_and_routing_i(fz[0]), .fuse_debug_and_core_option_i(fz[1]),
    .fuse_block_code_protect_i(fz[2]), .fuse_boot_code_protect_i(fz[3]),
    .fuse_block_write_protect_i(fz[4]), .fuse_boot_and_config_write_protect_i(fz[5]),
    .large_mem_i(lg), .prog_mode_i(pg), .table_rd_i(rd), .table_wr_i(tw),
    .table_addr_i(ta), .table_wdata_i(wd), .table_rdata_o(rdat),
    .table_rd_denied_o(rdn), .table_wr_denied_o(wdn), .stack_full_i(sf),
    .stack_underflow_i(su), .pm_addr_i(pa), .pm_ext_read_i(pr), .pm_wr_i(pw),
    .pm_read_blocked_o(prb), .pm_wr_blocked_o(pwb), .reset_pin_enable_o(rpe),
    .port_e_pin_3_input_en_o(pe3), .low_power_timer_osc_o(lpo),
    .analog_config_reset_o(acr), .capcomp2_on_port_c_pin_1_o(ccp),
    .debugger_active_o(dba), .extended_instr_enable_o(xin),
    .single_supply_prog_enable_o(ssp), .stack_reset_o(srs));
  // ==========================================================
  // Shared tasks
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmpf(input string nm, input logic e, input logic s);
    cmp(nm, {7'h00, e}, {7'h00, s});
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  function automatic int blk(input logic [21:0] a);
    if (a <= 22'h0007FF) return 4;
    if (a <= (lg ? 22'h003FFF : 22'h001FFF)) return 0;
    if (a <= (lg ? 22'h007FFF : 22'h003FFF)) return 1;
    if (a <= (lg ? 22'h00BFFF : 22'h005FFF)) return 2;
    if (a <= (lg ? 22'h00FFFF : 22'h007FFF)) return 3;
    return 5;
  endfunction
  function automatic logic hit(input logic [7:0] b, input logic [7:0] t, input int k);
    return k < 4 ? !b[k] : (k == 4 ? !t[6] : 1'b0);
  endfunction
  // ==========================================================
  // Scenarios
  task automatic start(input logic [47:0] f, input logic m);
    rst = 1'b1;
    lg = m;
    for (int i = 0; i < 6; i++) begin
      fz[i] = f[47 - 8 * i -: 8];
      ex[i] = fz[i] & MK[i];
    end
    repeat (16) tick;
    rst = 1'b0;
    repeat (2) tick;
    for (int i = 0; i < 6; i++) fz[i] = ~fz[i];
  endtask
  task automatic check_decode;
    cmpf("reset_pin", ex[0][7], rpe);
    cmpf("pin_input", !ex[0][7], pe3);
    cmpf("lp_osc", ex[0][2], lpo);
    cmp("analog", ex[0][1] ? 8'h00 : 8'h07, {4'h0, acr});
    cmpf("capcomp2_port_c", ex[0][0], ccp);
    cmpf("debugger", !ex[1][7], dba);
    cmpf("ext_instr", ex[1][6], xin);
    cmpf("single_supply", ex[1][2], ssp);
    sf = 1'b1;
    tick;
    cmpf("stack_reset", ex[1][0], srs);
    sf = 1'b0;
    su = 1'b1;
    tick;
    cmpf("stack_reset", ex[1][0], srs);
    su = 1'b0;
    tick;
    cmpf("stack_reset", 1'b0, srs);
  endtask
  task automatic read_all;
    rd = 1'b1;
    for (int i = 0; i < 6; i++) begin
      ta = AD[i];
      tick;
      cmp("rdata", ex[i], rdat);
      cmpf("rd_denied", 1'b0, rdn);
    end
    ta = 22'h300007;
    tick;
    cmp("rdata", 8'h00, rdat);
    ta = 22'h200000;
    tick;
    cmp("rdata", 8'h00, rdat);
    cmpf("rd_denied", 1'b1, rdn);
    rd = 1'b0;
  endtask
  task automatic wr_byte(input int i, input logic [7:0] d, input logic p, input logic dn);
    tw = 1'b1;
    pg = p;
    ta = AD[i];
    wd = d;
    if (p) ex[i] = ex[i] & d;
    tick;
    cmpf("wr_denied", dn, wdn);
  endtask
  task automatic check_pm;
    logic [21:0] pm [14] = '{22'h0007FF, 22'h000800, 22'h001FFF, 22'h002000, 22'h003FFF,
      22'h004000, 22'h005FFF, 22'h006000, 22'h007FFF, 22'h008000, 22'h00BFFF,
      22'h00C000, 22'h00FFFF, 22'h010000};
    pr = 1'b1;
    pw = 1'b1;
    for (int i = 0; i < 14; i++) begin
      pa = pm[i];
      tick;
      cmpf("pm_read_blocked", hit(ex[2], ex[3], blk(pm[i])), prb);
      cmpf("pm_wr_blocked", hit(ex[4], ex[5], blk(pm[i])), pwb);
    end
    pr = 1'b0;
    pw = 1'b0;
    pa = 22'h000000;
    tick;
    cmpf("pm_read_blocked", 1'b0, prb);
    cmpf("pm_wr_blocked", 1'b0, pwb);
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    start(48'h83850A000560, 1'b0);
    check_decode;
    read_all;
    check_pm;
    wr_byte(2, 8'hF7, 1'b1, 1'b0);
    wr_byte(2, 8'hFF, 1'b1, 1'b0);
    wr_byte(5, 8'h00, 1'b0, 1'b1);
    tw = 1'b0;
    read_all;
    check_pm;
    start(48'h7C7AF5FFFA40, 1'b1);
    check_decode;
    read_all;
    check_pm;
    wr_byte(4, 8'hFF, 1'b1, 1'b1);
    tw = 1'b0;
    wrap_up;
  end
  initial begin
    #50000;
    fail_count++;
    wrap_up;
  end
endmodule // cfpb_fuse_bank_bench
bind cfpb_fuse_bank cfpb_fuse_bank_monitor u_mon (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .prog_mode_i(prog_mode_i), .table_rd_i(table_rd_i), .table_wr_i(table_wr_i),
  .table_addr_i(table_addr_i), .table_rdata_o(table_rdata_o),
  .table_rd_denied_o(table_rd_denied_o), .table_wr_denied_o(table_wr_denied_o),
  .stack_full_i(stack_full_i), .stack_underflow_i(stack_underflow_i),
  .reset_pin_enable_o(reset_pin_enable_o), .port_e_pin_3_input_en_o(port_e_pin_3_input_en_o),
  .analog_config_reset_o(analog_config_reset_o), .debugger_active_o(debugger_active_o),
  .stack_reset_o(stack_reset_o));
